// ==== rmmsc_pkg.sv ====
package rmmsc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned T_IDLE_SW_MS  = 1;
  localparam int unsigned T_BUSY_SW_MS  = 2;
  localparam int unsigned T_UV_MS       = 500;
  localparam int unsigned T_OV_MS       = 1000;
  localparam int unsigned T_OT_MS       = 2000;
  localparam int unsigned T_LOG_MS      = 500;
  localparam int unsigned T_CHECK_MS    = 1;
  localparam int unsigned IDLE_SW_CYC   = T_IDLE_SW_MS * CYC_PER_MS;
  localparam int unsigned BUSY_SW_CYC   = T_BUSY_SW_MS * CYC_PER_MS;
  localparam int unsigned UV_CYC        = T_UV_MS * CYC_PER_MS;
  localparam int unsigned OV_CYC        = T_OV_MS * CYC_PER_MS;
  localparam int unsigned OT_CYC        = T_OT_MS * CYC_PER_MS;
  localparam int unsigned LOG_CYC       = T_LOG_MS * CYC_PER_MS;
  localparam int unsigned CHECK_CYC     = T_CHECK_MS * CYC_PER_MS;
  localparam int unsigned RELOAD_CYC    = 64;
  localparam int unsigned TX_BUF_BYTES  = 512;
  localparam int unsigned HOST_BURST    = 1000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_ADDR      = 8'h04;
  localparam logic [7:0]  OFF_STATUS    = 8'h08;
  localparam int unsigned CTRL_LOG_BIT  = 0;
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam logic [15:0] ADDR_ALL      = 16'hffff;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ****************************************************************
  // modes, fault codes, uart commands
  // ****************************************************************
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_WAKE      = 2'h1;
  localparam logic [1:0] MODE_SAVE      = 2'h2;
  localparam logic [1:0] MODE_SLEEP     = 2'h3;
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_UV        = 8'h01;
  localparam logic [7:0] CODE_OV        = 8'h02;
  localparam logic [7:0] CODE_OT        = 8'h03;
  localparam logic [7:0] CODE_OVOT      = 8'h04;
  localparam logic [7:0] LOG_LEAD       = 8'hff;
  localparam logic [7:0] CMD_SET        = 8'hc3;
  localparam logic [7:0] CMD_GET        = 8'hc4;
  localparam logic [7:0] CMD_P1         = 8'h03;
  localparam logic [7:0] CMD_P2         = 8'h01;
  localparam logic [7:0] LOG_ON         = 8'h01;
  localparam logic [7:0] LOG_OFF        = 8'h00;

  typedef enum logic [1:0] {
    RMMSC_INIT,
    RMMSC_RUN,
    RMMSC_RELOAD
  } rmmsc_state_t;

endpackage : rmmsc_pkg

// ==== rmmsc_top.sv ====
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
// Behaviour
// - busy low at power-up, self-check, set mode
// - busy rises after init, pins choose mode
// - busy low while transmit buffer not empty
// - busy high means host may burst 1000 bytes
// - busy high means empty buffer only
// - busy low while radio data awaits uart
// - busy low if any busy condition holds
// - mode pins ignored while busy low
// - deferred change waits 2ms after busy rises
// - reset or sleep exit reload, busy low
// - fault pin blinks per fault, solid for overvoltage plus overheat
// - radio transmit suppressed during any fault
// - fault log frame every 500ms when enabled
// - log frame ff ff ff plus code
// - c3 03 01 xx switches logging on or off
// - c4 03 01 reads logging, default off
// - mode 0: uart and radio transparent
// - mode 1: wake-up code before packets
// - mode 2: uart rx closed, no transmit
// - mode 3: deep sleep, commands still accepted
// - own address ffff transmits as broadcast
// - own address ffff receives as monitor
// - idle mode change takes effect after 1ms
// - pending work finishes before new mode
module rmmsc_top
  import rmmsc_pkg::*;
#(
  parameter int unsigned IDLE_SW  = rmmsc_pkg::IDLE_SW_CYC,
  parameter int unsigned BUSY_SW  = rmmsc_pkg::BUSY_SW_CYC,
  parameter int unsigned UV_HALF  = rmmsc_pkg::UV_CYC,
  parameter int unsigned OV_HALF  = rmmsc_pkg::OV_CYC,
  parameter int unsigned OT_HALF  = rmmsc_pkg::OT_CYC,
  parameter int unsigned LOG_GAP  = rmmsc_pkg::LOG_CYC,
  parameter int unsigned CHECK    = rmmsc_pkg::CHECK_CYC,
  parameter int unsigned RELOAD   = rmmsc_pkg::RELOAD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_select_high,
  input  wire logic        mode_select_low,
  input  wire logic        undervoltage,
  input  wire logic        overvoltage,
  input  wire logic        overheat,
  input  wire logic        tx_buf_pending,
  input  wire logic        rx_out_pending,
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_data,
  output logic             uart_tx_valid,
  output logic      [7:0]  uart_tx_data,
  input  wire logic        uart_tx_ready,
  output logic             busy_indicator,
  output logic             fault_indicator,
  output logic      [1:0]  active_mode,
  output logic             radio_tx_enable,
  output logic             wake_code_enable,
  output logic             uart_rx_enable,
  output logic             deep_sleep,
  output logic             broadcast_tx,
  output logic             monitor_rx
);
  import rmmsc_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // order: high, low, undervoltage, overvoltage, overheat
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [4:0] pin_s3_reg;
  logic [4:0] pin_reg;
  wire  [4:0] pin_raw = {mode_select_high, mode_select_low, undervoltage, overvoltage, overheat};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      pin_s3_reg <= 5'h00;
      pin_reg    <= 5'h00;
    end else if (clk_en) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // a bit only moves once two stages agree, so glitches die here
      pin_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  wire [1:0] pin_mode = pin_reg[4:3];
  wire       f_uv     = pin_reg[2];
  wire       f_ov     = pin_reg[1];
  wire       f_ot     = pin_reg[0];
  wire       fault    = f_uv | f_ov | f_ot;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic        log_en_reg;
  logic [15:0] own_addr_reg;
  logic [31:0] prdata_next;
  logic        pslverr_next;

  wire setup     = psel & ~penable;
  wire access    = psel & penable & pready;
  wire hit_ctrl  = (paddr == OFF_CTRL);
  wire hit_addr  = (paddr == OFF_ADDR);
  wire hit_stat  = (paddr == OFF_STATUS);
  wire wr_ctrl   = access & pwrite & hit_ctrl & ~pslverr;
  wire wr_addr   = access & pwrite & hit_addr & ~pslverr;

  rmmsc_state_t state_reg;
  logic [7:0]   code_reg;
  wire  [31:0]  status_word = {16'h0000, code_reg, 2'h0, active_mode,
                               (state_reg == RMMSC_RUN), fault, log_en_reg, busy_indicator};

  always_comb begin
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (hit_ctrl) begin
      prdata_next = {31'h0000_0000, log_en_reg};
    end else if (hit_addr) begin
      prdata_next = {16'h0000, own_addr_reg};
    end else if (hit_stat) begin
      prdata_next  = status_word;
      pslverr_next = pwrite;
    end else begin
      pslverr_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & pslverr_next;
      prdata  <= (setup & ~pwrite) ? prdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_reg <= ADDR_RESET;
    end else if (clk_en && wr_addr) begin
      own_addr_reg <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // uart command parser
  // ****************************************************************
  logic [23:0] hist_reg;
  wire rx_take  = uart_rx_valid & uart_rx_enable;
  wire cmd_set  = rx_take & (hist_reg == {CMD_SET, CMD_P1, CMD_P2})
                  & ((uart_rx_data == LOG_ON) | (uart_rx_data == LOG_OFF));
  wire cmd_get  = rx_take & (hist_reg[15:0] == {CMD_GET, CMD_P1}) & (uart_rx_data == CMD_P2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg <= 24'h00_0000;
    end else if (clk_en && rx_take) begin
      // cleared after a match so a trailing byte cannot re-trigger
      hist_reg <= (cmd_set | cmd_get) ? 24'h00_0000 : {hist_reg[15:0], uart_rx_data};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_en_reg <= CTRL_RESET[CTRL_LOG_BIT];
    end else if (clk_en) begin
      if (wr_ctrl) begin
        log_en_reg <= pwdata[CTRL_LOG_BIT];
      end else if (cmd_set) begin
        log_en_reg <= uart_rx_data[0];
      end
    end
  end

  // ****************************************************************
  // mode control
  // ****************************************************************
  logic [31:0] cnt_reg;
  logic        defer_reg;
  wire  pending   = tx_buf_pending | rx_out_pending;
  wire  change    = (pin_mode != active_mode);
  wire  sw_due    = cnt_reg >= (defer_reg ? BUSY_SW : IDLE_SW);
  wire  apply     = (state_reg == RMMSC_RUN) & change & ~pending & busy_indicator & sw_due;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= RMMSC_INIT;
      cnt_reg     <= 32'h0000_0000;
      defer_reg   <= 1'b0;
      active_mode <= MODE_NORMAL;
    end else if (clk_en) begin
      case (state_reg)
        RMMSC_INIT, RMMSC_RELOAD: begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
          if (cnt_reg >= ((state_reg == RMMSC_INIT) ? CHECK : RELOAD) - 1) begin
            state_reg   <= RMMSC_RUN;
            active_mode <= pin_mode;
            cnt_reg     <= 32'h0000_0000;
            defer_reg   <= 1'b0;
          end
        end
        RMMSC_RUN: begin
          if (!change) begin
            cnt_reg   <= 32'h0000_0000;
            defer_reg <= 1'b0;
          end else if (pending || !busy_indicator) begin
            // pins are not looked at while busy; timing restarts on release
            cnt_reg   <= 32'h0000_0000;
            defer_reg <= 1'b1;
          end else if (apply) begin
            active_mode <= pin_mode;
            cnt_reg     <= 32'h0000_0000;
            defer_reg   <= 1'b0;
            if (active_mode == MODE_SLEEP) begin
              state_reg <= RMMSC_RELOAD;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        default: begin
          state_reg <= RMMSC_INIT;
          cnt_reg   <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // busy indicator and mode outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_indicator   <= 1'b0;
      radio_tx_enable  <= 1'b0;
      wake_code_enable <= 1'b0;
      uart_rx_enable   <= 1'b0;
      deep_sleep       <= 1'b0;
      broadcast_tx     <= 1'b0;
      monitor_rx       <= 1'b0;
    end else if (clk_en) begin
      // high only with an empty buffer; the last packet may still be on air
      busy_indicator   <= (state_reg == RMMSC_RUN) & ~pending & ~apply;
      radio_tx_enable  <= (state_reg == RMMSC_RUN) & ~active_mode[1] & ~fault;
      wake_code_enable <= (active_mode == MODE_WAKE);
      uart_rx_enable   <= (active_mode != MODE_SAVE);
      deep_sleep       <= (state_reg == RMMSC_RUN) & (active_mode == MODE_SLEEP);
      broadcast_tx     <= (own_addr_reg == ADDR_ALL);
      monitor_rx       <= (own_addr_reg == ADDR_ALL);
    end
  end

  // ****************************************************************
  // fault indicator
  // ****************************************************************
  logic [31:0] blink_reg;
  logic [7:0]  code_next;
  logic [31:0] half_next;

  always_comb begin
    code_next = CODE_NONE;
    half_next = UV_HALF;
    if (f_ov && f_ot) begin
      code_next = CODE_OVOT;
    end else if (f_ov) begin
      code_next = CODE_OV;
      half_next = OV_HALF;
    end else if (f_ot) begin
      code_next = CODE_OT;
      half_next = OT_HALF;
    end else if (f_uv) begin
      code_next = CODE_UV;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg        <= CODE_NONE;
      blink_reg       <= 32'h0000_0000;
      fault_indicator <= 1'b0;
    end else if (clk_en) begin
      code_reg <= code_next;
      if (code_next != code_reg) begin
        blink_reg       <= 32'h0000_0000;
        fault_indicator <= (code_next != CODE_NONE);
      end else if (code_reg == CODE_OVOT) begin
        fault_indicator <= 1'b1;
      end else if (code_reg == CODE_NONE) begin
        fault_indicator <= 1'b0;
      end else if (blink_reg >= half_next - 1) begin
        blink_reg       <= 32'h0000_0000;
        fault_indicator <= ~fault_indicator;
      end else begin
        blink_reg <= blink_reg + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // uart frame sender: status reply and fault log
  // ****************************************************************
  // a reply waiting behind a log frame is held, not dropped
  logic [31:0] frame_reg;
  logic [2:0]  left_reg;
  logic        get_wait_reg;
  logic [31:0] log_cnt_reg;
  logic        log_due_reg;
  wire         log_tick = log_cnt_reg >= LOG_GAP - 1;
  wire         tx_done  = uart_tx_valid & uart_tx_ready;
  wire         idle_tx  = (left_reg == 3'h0) & ~uart_tx_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_cnt_reg <= 32'h0000_0000;
      log_due_reg <= 1'b0;
    end else if (clk_en) begin
      if (!(fault && log_en_reg)) begin
        log_cnt_reg <= 32'h0000_0000;
        log_due_reg <= fault & log_en_reg;
      end else if (log_tick) begin
        log_cnt_reg <= 32'h0000_0000;
        log_due_reg <= 1'b1;
      end else begin
        log_cnt_reg <= log_cnt_reg + 32'h0000_0001;
        if (idle_tx && !get_wait_reg) begin
          log_due_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg     <= 32'h0000_0000;
      left_reg      <= 3'h0;
      get_wait_reg  <= 1'b0;
      uart_tx_valid <= 1'b0;
      uart_tx_data  <= 8'h00;
    end else if (clk_en) begin
      if (cmd_get) begin
        get_wait_reg <= 1'b1;
      end
      if (idle_tx && (get_wait_reg || cmd_get)) begin
        frame_reg    <= {CMD_GET, CMD_P1, CMD_P2, 7'h00, log_en_reg};
        left_reg     <= 3'h4;
        // a request arriving while an older one is served stays pending
        get_wait_reg <= get_wait_reg & cmd_get;
      end else if (idle_tx && log_due_reg && fault && log_en_reg) begin
        frame_reg <= {LOG_LEAD, LOG_LEAD, LOG_LEAD, code_reg};
        left_reg  <= 3'h4;
      end else if ((left_reg != 3'h0) && (!uart_tx_valid || tx_done)) begin
        uart_tx_valid <= 1'b1;
        uart_tx_data  <= frame_reg[31:24];
        frame_reg     <= {frame_reg[23:0], 8'h00};
        left_reg      <= left_reg - 3'h1;
      end else if (tx_done) begin
        uart_tx_valid <= 1'b0;
      end
    end
  end

endmodule : rmmsc_top

// ==== rmmsc_asserts.sv ====
`timescale 1ns/100ps
module rmmsc_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       clk_en,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       tx_buf_pending,
  input wire logic       rx_out_pending,
  input wire logic       undervoltage,
  input wire logic       overvoltage,
  input wire logic       overheat,
  input wire logic       busy_indicator,
  input wire logic       fault_indicator,
  input wire logic [1:0] active_mode,
  input wire logic       radio_tx_enable,
  input wire logic       deep_sleep
);
  import rmmsc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire any_fault = undervoltage || overvoltage || overheat;
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_access;
    pready ##1 !pready;
  endsequence
  apb_one_wait_a: assert property (s_setup |=> s_access) else $error("apb answer late");
  init_busy_low_a: assert property ($rose(presetn) |-> !busy_indicator [*8])
    else $error("busy high during self-check");
  tx_busy_low_a: assert property (clk_en && tx_buf_pending |=> !busy_indicator)
    else $error("busy high with tx pending");
  rx_busy_low_a: assert property (clk_en && rx_out_pending |=> !busy_indicator)
    else $error("busy high with rx pending");
  mode_when_idle_a: assert property (clk_en && (tx_buf_pending || rx_out_pending)
    |=> $stable(active_mode)) else $error("mode changed while busy");
  fault_tx_off_a: assert property (any_fault [*6] |-> !radio_tx_enable)
    else $error("radio on during fault");
  lamp_solid_a: assert property ((overvoltage && overheat) [*6] |-> fault_indicator)
    else $error("lamp not solid");
  lamp_dark_a: assert property (!any_fault [*6] |-> !fault_indicator)
    else $error("lamp lit without fault");
  sleep_exit_a: assert property ($fell(deep_sleep) |-> !busy_indicator [*2])
    else $error("busy high at sleep exit");
endmodule : rmmsc_asserts

// ==== rmmsc_host.sv ====
`timescale 1ns/100ps
module rmmsc_host (
  input  wire logic       pclk,
  output logic            uart_rx_valid,
  output logic      [7:0] uart_rx_data,
  input  wire logic       uart_tx_valid,
  input  wire logic [7:0] uart_tx_data,
  output logic            uart_tx_ready
);
  logic [7:0] got [$];
  logic       stall_reg;
  initial begin
    uart_rx_valid = 1'b0;
    uart_rx_data  = 8'h00;
    uart_tx_ready = 1'b0;
    stall_reg     = 1'b0;
  end
  // slow sink drops ready every other cycle
  always @(posedge pclk) begin
    if (uart_tx_valid && uart_tx_ready)
      got.push_back(uart_tx_data);
    uart_tx_ready <= stall_reg ? ~uart_tx_ready : 1'b1;
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge pclk);
    uart_rx_valid <= 1'b1;
    uart_rx_data  <= b;
    @(posedge pclk);
    uart_rx_valid <= 1'b0;
    uart_rx_data  <= ~b;
  endtask : send_byte
endmodule : rmmsc_host

// ==== rmmsc_top_test.sv ====
`timescale 1ns/100ps
module rmmsc_top_test;
  import rmmsc_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, uart_rx_data, uart_tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic        mode_select_high, mode_select_low, undervoltage, overvoltage, overheat;
  logic        tx_buf_pending, rx_out_pending, uart_rx_valid, uart_tx_valid, uart_tx_ready;
  logic        busy_indicator, fault_indicator, radio_tx_enable, wake_code_enable;
  logic        uart_rx_enable, deep_sleep, broadcast_tx, monitor_rx, er, v;
  logic [1:0]  active_mode;
  int          mismatches, num_checks, cycles, n, t1;
  // pins, mode, radio, wake, uart rx, sleep
  logic [7:0]  mrow [5] = '{8'h5e, 8'h0a, 8'ha0, 8'hf3, 8'h0a};
  // faults, frame code, lamp half period (0 = solid)
  logic [18:0] frow [4] = '{{3'h4, CODE_UV, 8'h0a}, {3'h2, CODE_OV, 8'h14},
                            {3'h1, CODE_OT, 8'h28}, {3'h3, CODE_OVOT, 8'h00}};
  rmmsc_top #(.IDLE_SW(20), .BUSY_SW(40), .UV_HALF(10), .OV_HALF(20), .OT_HALF(40),
    .LOG_GAP(50), .CHECK(8)) rmmsc_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_select_high(mode_select_high),
    .mode_select_low(mode_select_low), .undervoltage(undervoltage),
    .overvoltage(overvoltage), .overheat(overheat), .tx_buf_pending(tx_buf_pending),
    .rx_out_pending(rx_out_pending), .uart_rx_valid(uart_rx_valid),
    .uart_rx_data(uart_rx_data), .uart_tx_valid(uart_tx_valid),
    .uart_tx_data(uart_tx_data), .uart_tx_ready(uart_tx_ready),
    .busy_indicator(busy_indicator), .fault_indicator(fault_indicator),
    .active_mode(active_mode), .radio_tx_enable(radio_tx_enable),
    .wake_code_enable(wake_code_enable), .uart_rx_enable(uart_rx_enable),
    .deep_sleep(deep_sleep), .broadcast_tx(broadcast_tx), .monitor_rx(monitor_rx));
  rmmsc_host rmmsc_host_i (.pclk(pclk), .uart_rx_valid(uart_rx_valid),
    .uart_rx_data(uart_rx_data), .uart_tx_valid(uart_tx_valid),
    .uart_tx_data(uart_tx_data), .uart_tx_ready(uart_tx_ready));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check
  // one setup edge, then hold until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send4(input logic [31:0] w);
    for (int i = 3; i >= 0; i--)
      rmmsc_host_i.send_byte(w[i*8+:8]);
  endtask : send4
  task automatic wait_busy;
    for (n = 0; n < 400 && busy_indicator !== 1'b1; n++)
      @(posedge pclk);
  endtask : wait_busy
  task automatic wait_got(input int k);
    // polled off the edge so the sink's push is never raced
    for (n = 0; n < 400 && rmmsc_host_i.got.size() < k; n++)
      @(negedge pclk);
    @(posedge pclk);
  endtask : wait_got
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(busy_indicator === 1'b0 && active_mode === 2'h0, "reset outputs");
    presetn <= 1'b1;
    wait_busy();
    check(n >= 8 && n <= 12, "self-check length");
  endtask : do_reset
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mode_select_high, mode_select_low} = '0;
    {undervoltage, overvoltage, overheat, tx_buf_pending, rx_out_pending} = '0;
    clk_en = 1'b1;
    do_reset();
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd === CTRL_RESET, "ctrl reset");
    apb(1'b0, OFF_ADDR, 32'h0);
    check(rd[15:0] === ADDR_RESET, "addr reset");
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd[1] === 1'b0 && rd[0] === 1'b1, "status reset");
    apb(1'b0, 8'h0c, 32'h0);
    check(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, OFF_STATUS, 32'h1);
    check(er === 1'b1, "status write");
    apb(1'b1, OFF_ADDR, {16'h0, ADDR_ALL});
    repeat (4) @(posedge pclk);
    check(broadcast_tx === 1'b1 && monitor_rx === 1'b1, "all address");
    rmmsc_host_i.send_byte(CMD_GET);
    rmmsc_host_i.send_byte(CMD_P1);
    rmmsc_host_i.send_byte(CMD_P2);
    wait_got(4);
    check({rmmsc_host_i.got[0], rmmsc_host_i.got[1], rmmsc_host_i.got[2],
      rmmsc_host_i.got[3]} === {CMD_GET, CMD_P1, CMD_P2, LOG_OFF}, "log read");
    // ****************************************************************
    // mode rows, changes while idle
    // ****************************************************************
    foreach (mrow[i]) begin
      {mode_select_high, mode_select_low} <= mrow[i][7:6];
      @(posedge pclk);
      for (n = 0; n < 100 && active_mode !== mrow[i][5:4]; n++)
        @(posedge pclk);
      check(n >= 20 && n <= 28, "idle switch time");
      wait_busy();
      repeat (4) @(posedge pclk);
      check({radio_tx_enable, wake_code_enable, uart_rx_enable, deep_sleep} === mrow[i][3:0],
        "mode outputs");
    end
    // ****************************************************************
    // change while busy is deferred
    // ****************************************************************
    clk_en         <= 1'b0;
    tx_buf_pending <= 1'b1;
    repeat (10) @(posedge pclk);
    check(busy_indicator === 1'b1 && active_mode === MODE_NORMAL, "frozen");
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    check(busy_indicator === 1'b0, "busy with tx pending");
    rx_out_pending <= 1'b1;
    tx_buf_pending <= 1'b0;
    mode_select_low <= 1'b1;
    repeat (60) @(posedge pclk);
    check(busy_indicator === 1'b0 && active_mode === MODE_NORMAL, "deferred");
    rx_out_pending <= 1'b0;
    wait_busy();
    for (n = 0; n < 100 && active_mode !== MODE_WAKE; n++)
      @(posedge pclk);
    check(n >= 39 && n <= 48, "busy switch time");
    // ****************************************************************
    // fault lamp and log frames, slow host sink
    // ****************************************************************
    rmmsc_host_i.stall_reg <= 1'b1;
    send4({CMD_SET, CMD_P1, CMD_P2, LOG_ON});
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd[1] === 1'b1, "log enabled");
    foreach (frow[i]) begin
      rmmsc_host_i.got.delete();
      {undervoltage, overvoltage, overheat} <= frow[i][18:16];
      wait_got(1);
      t1 = int'($time);
      wait_got(5);
      check(int'($time) - t1 === 50 * 8, "log period");
      check({rmmsc_host_i.got[0], rmmsc_host_i.got[1], rmmsc_host_i.got[2],
        rmmsc_host_i.got[3]} === {LOG_LEAD, LOG_LEAD, LOG_LEAD, frow[i][15:8]}, "frame");
      check(radio_tx_enable === 1'b0, "radio during fault");
      v = fault_indicator;
      for (n = 0; n < 100 && fault_indicator === v; n++)
        @(posedge pclk);
      v = fault_indicator;
      for (n = 0; n < 100 && fault_indicator === v; n++)
        @(posedge pclk);
      if (frow[i][7:0] == 8'h00)
        check(n === 100 && fault_indicator === 1'b1, "lamp solid");
      else
        check(n === int'(frow[i][7:0]), "lamp period");
      {undervoltage, overvoltage, overheat} <= 3'h0;
      repeat (30) @(posedge pclk);
      check(radio_tx_enable === 1'b1, "radio resumes");
    end
    send4({CMD_SET, CMD_P1, CMD_P2, LOG_OFF});
    rmmsc_host_i.got.delete();
    undervoltage <= 1'b1;
    repeat (120) @(posedge pclk);
    check(rmmsc_host_i.got.size() === 0, "logging off");
    undervoltage <= 1'b0;
    // second reset, pins still at mode 1
    do_reset();
    check(active_mode === MODE_WAKE, "mode from pins at start");
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd[1] === 1'b0, "log default after reset");
    give_verdict();
  end
endmodule : rmmsc_top_test
bind rmmsc_top rmmsc_asserts rmmsc_asserts_i (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready),
  .tx_buf_pending(tx_buf_pending), .rx_out_pending(rx_out_pending),
  .undervoltage(undervoltage), .overvoltage(overvoltage), .overheat(overheat),
  .busy_indicator(busy_indicator), .fault_indicator(fault_indicator),
  .active_mode(active_mode), .radio_tx_enable(radio_tx_enable), .deep_sleep(deep_sleep));
